// ==== rtl/sbac_params.svh ====
// Purpose: Offsets, field positions and reset values of the burst SRAM front end
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SBAC_PARAMS_SVH
`define SBAC_PARAMS_SVH
// ==========================================
// Register offsets
`define SBAC_OFF_CTRL     4'h0
`define SBAC_OFF_STAT     4'h4
`define SBAC_OFF_ADDR     4'h8
// ==========================================
// Control fields and reset value
`define SBAC_CTRL_ORG_LSB 0
`define SBAC_CTRL_ORG_MSB 1
`define SBAC_CTRL_RST     2'h2
// ==========================================
// Status fields
`define SBAC_STAT_IDX_LSB 0
`define SBAC_STAT_IDX_MSB 1
`define SBAC_STAT_SEL     2
`define SBAC_STAT_PDN     3
`define SBAC_STAT_RD      4
`define SBAC_STAT_WR      5
// ==========================================
// Data word layout
`define SBAC_PAR_LSB      32
`define SBAC_WORD_W       36
`endif

// ==== rtl/sbac_pkg.sv ====
// Purpose: Types of the burst SRAM front end
// Assumes: Constants live in sbac_params.svh
// Notes:   None
package sbac_pkg;
    // ==========================================
    // Organisations
    typedef enum logic [1:0] {
        SBAC_X18 = 2'h0,
        SBAC_X32 = 2'h1,
        SBAC_X36 = 2'h2
    } sbac_org_t;
    // ==========================================
    // Cycle states
    typedef enum logic [1:0] {
        SBAC_PDN = 2'h0,
        SBAC_RD  = 2'h1,
        SBAC_WR  = 2'h2
    } sbac_state_t;
endpackage

// ==== rtl/sbac_burst_if.sv ====
// Purpose: Link between the front end and its burst counter
// Assumes: One clock
// Notes:   None
interface sbac_burst_if;
    logic       load;
    logic       advance;
    logic       interleave;
    logic [1:0] first_idx;
    logic [1:0] cur_idx;
    logic [1:0] nxt_idx;
    modport ctr (input load, advance, interleave, first_idx, output cur_idx, nxt_idx);
    modport ctl (output load, advance, interleave, first_idx, input cur_idx, nxt_idx);
endinterface

// ==== rtl/sbac_burst_ctr.sv ====
// Purpose: Two-bit burst index, linear or interleaved
// Assumes: Order select static during operation
// Notes:   Wraps after the fourth access
module sbac_burst_ctr
    import sbac_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    sbac_burst_if.ctr bi
);
    logic [1:0] first_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_inc;

    function automatic logic [1:0] idx_of(input logic il, input logic [1:0] f,
                                          input logic [1:0] c);
        idx_of = il ? (f ^ c) : 2'(f + c);
    endfunction

    // ==========================================
    // Index arithmetic
    assign cnt_inc    = 2'(cnt_q + 2'h1);
    assign bi.cur_idx = idx_of(bi.interleave, first_q, cnt_q);
    assign bi.nxt_idx = idx_of(bi.interleave, first_q, cnt_inc);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 2'h0;
            cnt_q   <= 2'h0;
        end else if (bi.load) begin
            first_q <= bi.first_idx;
            cnt_q   <= 2'h0;
        end else if (bi.advance) begin
            cnt_q   <= cnt_inc;
        end
    end

    property p_hold;
        @(posedge clock) disable iff (sys_rst)
        !bi.load && !bi.advance |=> bi.cur_idx == $past(bi.cur_idx);
    endproperty
    a_hold: assert property (p_hold) else $error("index moved without advance");

    property p_linear;
        @(posedge clock) disable iff (sys_rst)
        !bi.load && bi.advance && !bi.interleave && $stable(bi.interleave)
            ##0 1 |=> !bi.interleave |-> bi.cur_idx == 2'($past(bi.cur_idx) + 2'h1);
    endproperty
    a_linear: assert property (p_linear) else $error("linear step wrong");

    property p_ilv;
        @(posedge clock) disable iff (sys_rst)
        bi.load ##1 (bi.interleave && bi.advance && !bi.load)
            |=> bi.cur_idx == ($past(bi.first_idx, 2) ^ 2'h1);
    endproperty
    a_ilv: assert property (p_ilv) else $error("interleaved second index wrong");
endmodule // sbac_burst_ctr

// ==== rtl/sbac_lane_map.sv ====
// Purpose: Byte lane and parity masks per organisation
// Assumes: Lane n data at bits 8n+7:8n, parity at bit 32+n
// Notes:   Combinational
module sbac_lane_map
    import sbac_pkg::*;
(
    input  wire logic       global_write_n,
    input  wire logic       byte_write_enable_n,
    input  wire logic [3:0] lane_write_n,
    input  wire sbac_org_t  org,
    output logic            write_any,
    output logic [35:0]     wr_mask,
    output logic [35:0]     rd_mask
);
    logic [3:0] lane_en;
    logic [3:0] par_en;
    logic [3:0] lane_wr;

    function automatic logic [35:0] expand(input logic [3:0] ln, input logic [3:0] pr);
        expand = {pr, {8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    endfunction

    // ==========================================
    // Lane decode
    assign lane_en   = (org == SBAC_X18) ? 4'h3 : 4'hF;
    assign par_en    = (org == SBAC_X32) ? 4'h0 : lane_en;
    assign lane_wr   = !global_write_n ? 4'hF
                     : (!byte_write_enable_n ? ~lane_write_n : 4'h0);
    assign write_any = |(lane_wr & lane_en);
    assign wr_mask   = expand(lane_wr & lane_en, lane_wr & par_en);
    assign rd_mask   = expand(lane_en, par_en);
endmodule // sbac_lane_map

// ==== rtl/sbac_top.sv ====
// Purpose: Address status and burst control of a pipelined burst SRAM
// Assumes: Pins synchronous to clock; registers over Avalon-MM
// Notes:   Array in flip-flops, read data two edges after address
//
// Contract
// - Processor strobe low ends any burst and loads a new address.
// - A processor-strobe access is always a read.
// - Processor-strobe read ignores write controls and controller strobe, obeys chip enables.
// - Processor strobe is ignored while primary chip enable is high.
// - Processor strobe with secondary enables off deselects into power-down.
// - Controller strobe low ends any burst and loads a new address.
// - Controller strobe with primary enable low reads or writes per write controls.
// - Controller strobe with primary enable high deselects into power-down.
// - Order select low gives linear burst order.
// - Order select high gives interleaved burst order.
// - Two byte lanes in 18-bit, four lanes in 32/36-bit organisation.
// - Write data is captured at the rising edge of the write cycle.
// - 32-bit organisation has no parity data.
// - Parity on lanes a,b in 18-bit, a to d in 36-bit.
// - Interleaved index is first index XOR count 1, 2, 3.
// - Linear index increments by one and wraps modulo four.
// - Burst counter steps only when advance is low; else holds.
// - Global write writes all lanes; else byte enable writes selected lanes.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`include "sbac_params.svh"
module sbac_top
    import sbac_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic              chip_sel_n,
    input  wire logic              chip_sel_hi,
    input  wire logic              chip_sel_secondary_n,
    input  wire logic              proc_addr_strobe_n,
    input  wire logic              ctrl_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              global_write_n,
    input  wire logic              byte_write_enable_n,
    input  wire logic              lane_a_write_n,
    input  wire logic              lane_b_write_n,
    input  wire logic              lane_c_write_n,
    input  wire logic              lane_d_write_n,
    input  wire logic              burst_order_sel,
    input  wire logic              out_enable_n,
    input  wire logic [35:0]       data_in,
    output logic [35:0]            data_out,
    output logic                   data_oe_n
);
    localparam int DEPTH = 2 ** ADDR_W;

    if (ADDR_W < 2 || ADDR_W > 12) begin : g_chk
        $error("ADDR_W must lie in 2..12");
    end

    // ==========================================
    // Declarations
    sbac_burst_if bi ();

    sbac_state_t         state_q;
    sbac_state_t         state_d;
    sbac_org_t           org_q;
    logic [ADDR_W-3:0]   addr_hi_q;
    logic [ADDR_W-1:0]   addr_cur;
    logic [ADDR_W-1:0]   eff_addr;
    logic [35:0]         mem_q [DEPTH];
    logic [35:0]         rd_word_q;
    logic                rd_vld_q;
    logic [35:0]         out_q;
    logic                out_vld_q;
    logic                pdn_q;
    logic                ack_q;
    logic [31:0]         bus_rd_q;
    logic [31:0]         bus_rd_d;
    logic                proc_take;
    logic                ctrl_take;
    logic                load;
    logic                ce_ok;
    logic                start;
    logic                desel;
    logic                active;
    logic                wr_now;
    logic                write_any;
    logic [35:0]         wr_mask;
    logic [35:0]         rd_mask;
    logic                bus_req;
    logic                bus_wr;
    logic [1:0]          org_wr;

    // ==========================================
    // Strobe decode
    assign proc_take = !proc_addr_strobe_n && !chip_sel_n;
    assign ctrl_take = !ctrl_addr_strobe_n && !proc_take;
    assign load      = proc_take || ctrl_take;
    assign ce_ok     = !chip_sel_n && chip_sel_hi && !chip_sel_secondary_n;
    assign start     = load && ce_ok;
    assign desel     = load && !ce_ok;
    assign active    = start || (!load && state_q != SBAC_PDN);
    assign wr_now    = start ? (ctrl_take && write_any) : write_any;

    // ==========================================
    // Burst counter
    assign bi.load       = load;
    assign bi.advance    = !load && state_q != SBAC_PDN && !burst_advance_n;
    assign bi.interleave = burst_order_sel;
    assign bi.first_idx  = ext_addr[1:0];

    sbac_burst_ctr u_ctr (
        .clock   (clock),
        .sys_rst (sys_rst),
        .bi      (bi.ctr)
    );

    assign addr_cur = {addr_hi_q, bi.cur_idx};
    assign eff_addr = load ? ext_addr
                    : (bi.advance ? {addr_hi_q, bi.nxt_idx} : addr_cur);

    sbac_lane_map u_lanes (
        .global_write_n      (global_write_n),
        .byte_write_enable_n (byte_write_enable_n),
        .lane_write_n        ({lane_d_write_n, lane_c_write_n,
                               lane_b_write_n, lane_a_write_n}),
        .org                 (org_q),
        .write_any           (write_any),
        .wr_mask             (wr_mask),
        .rd_mask             (rd_mask)
    );

    // ==========================================
    // Cycle state
    always_comb begin
        state_d = SBAC_PDN;
        unique case (state_q)
            SBAC_PDN, SBAC_RD, SBAC_WR: begin
                if (desel || !active) begin
                    state_d = SBAC_PDN;
                end else if (wr_now) begin
                    state_d = SBAC_WR;
                end else begin
                    state_d = SBAC_RD;
                end
            end
            default: state_d = SBAC_PDN;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= SBAC_PDN;
            addr_hi_q <= '0;
            pdn_q     <= 1'b1;
        end else begin
            state_q <= state_d;
            pdn_q   <= (state_d == SBAC_PDN);
            if (load) begin
                addr_hi_q <= ext_addr[ADDR_W-1:2];
            end
        end
    end

    // ==========================================
    // Array
    always_ff @(posedge clock) begin
        if (active && !desel && wr_now) begin
            mem_q[eff_addr] <= (mem_q[eff_addr] & ~wr_mask)
                             | (data_in & wr_mask);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_word_q <= 36'h0_0000_0000;
            rd_vld_q  <= 1'b0;
            out_q     <= 36'h0_0000_0000;
            out_vld_q <= 1'b0;
        end else begin
            rd_vld_q  <= (state_d == SBAC_RD);
            rd_word_q <= mem_q[eff_addr] & rd_mask;
            out_vld_q <= rd_vld_q;
            out_q     <= rd_word_q;
        end
    end

    assign data_out  = out_q;
    assign data_oe_n = !(out_vld_q && !out_enable_n);

    // ==========================================
    // Avalon slave
    assign bus_req         = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack_q;
    assign bus_wr          = avs_write && ack_q;
    assign org_wr          = avs_writedata[`SBAC_CTRL_ORG_MSB:`SBAC_CTRL_ORG_LSB];
    assign avs_readdata    = bus_rd_q;

    always_comb begin
        bus_rd_d = 32'h0000_0000;
        unique case (avs_address)
            `SBAC_OFF_CTRL: begin
                bus_rd_d[`SBAC_CTRL_ORG_MSB:`SBAC_CTRL_ORG_LSB] = org_q;
            end
            `SBAC_OFF_STAT: begin
                bus_rd_d[`SBAC_STAT_IDX_MSB:`SBAC_STAT_IDX_LSB] = bi.cur_idx;
                bus_rd_d[`SBAC_STAT_SEL] = (state_q != SBAC_PDN);
                bus_rd_d[`SBAC_STAT_PDN] = pdn_q;
                bus_rd_d[`SBAC_STAT_RD]  = (state_q == SBAC_RD);
                bus_rd_d[`SBAC_STAT_WR]  = (state_q == SBAC_WR);
            end
            `SBAC_OFF_ADDR: begin
                bus_rd_d[ADDR_W-1:0] = addr_cur;
            end
            default: bus_rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q    <= 1'b0;
            bus_rd_q <= 32'h0000_0000;
            org_q    <= sbac_org_t'(`SBAC_CTRL_RST);
        end else begin
            ack_q <= bus_req && !ack_q;
            if (avs_read && !ack_q) begin
                bus_rd_q <= bus_rd_d;
            end
            if (bus_wr && avs_address == `SBAC_OFF_CTRL && avs_byteenable[0]
                && org_wr != 2'h3) begin
                org_q <= sbac_org_t'(org_wr);
            end
        end
    end

    // ==========================================
    // Checks
    property p_proc_rd;
        @(posedge clock) disable iff (sys_rst)
        proc_take && ce_ok |=> state_q == SBAC_RD && rd_vld_q;
    endproperty
    a_proc_rd: assert property (p_proc_rd) else $error("processor strobe not a read");

    property p_new_addr;
        @(posedge clock) disable iff (sys_rst)
        load |=> addr_cur == $past(ext_addr);
    endproperty
    a_new_addr: assert property (p_new_addr) else $error("new address not loaded");

    property p_ignore;
        @(posedge clock) disable iff (sys_rst)
        chip_sel_n && ctrl_addr_strobe_n |=> addr_hi_q == $past(addr_hi_q);
    endproperty
    a_ignore: assert property (p_ignore) else $error("strobe taken with enable high");

    property p_pdn_sec;
        @(posedge clock) disable iff (sys_rst)
        proc_take && !chip_sel_hi |=> pdn_q && state_q == SBAC_PDN ##1 !out_vld_q;
    endproperty
    a_pdn_sec: assert property (p_pdn_sec) else $error("no power-down on secondary");

    property p_pdn_ctl;
        @(posedge clock) disable iff (sys_rst)
        !ctrl_addr_strobe_n && chip_sel_n |=> pdn_q;
    endproperty
    a_pdn_ctl: assert property (p_pdn_ctl) else $error("no power-down on controller");

    property p_ctl_wr;
        @(posedge clock) disable iff (sys_rst)
        ctrl_take && ce_ok && write_any |=> state_q == SBAC_WR && !rd_vld_q;
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("controller write not taken");

    property p_no_par;
        @(posedge clock) disable iff (sys_rst)
        org_q == SBAC_X32 [*3] |-> data_out[35:32] == 4'h0;
    endproperty
    a_no_par: assert property (p_no_par) else $error("parity seen in 32-bit mode");

    property p_desel_sec;
        @(posedge clock) disable iff (sys_rst)
        proc_take && chip_sel_secondary_n |=> pdn_q && state_q == SBAC_PDN;
    endproperty
    a_desel_sec: assert property (p_desel_sec) else $error("no power-down");

    property p_ctl_rd;
        @(posedge clock) disable iff (sys_rst)
        ctrl_take && ce_ok && !write_any |=> state_q == SBAC_RD && rd_vld_q;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("controller read not taken");

    property p_hold_addr;
        @(posedge clock) disable iff (sys_rst)
        !load && state_q != SBAC_PDN && burst_advance_n |=> addr_cur == $past(addr_cur);
    endproperty
    a_hold_addr: assert property (p_hold_addr) else $error("address moved in wait");

    property p_both_rd;
        @(posedge clock) disable iff (sys_rst)
        !proc_addr_strobe_n && !ctrl_addr_strobe_n && ce_ok |=> state_q == SBAC_RD && rd_vld_q;
    endproperty
    a_both_rd: assert property (p_both_rd) else $error("both strobes not a read");
endmodule // sbac_top

// ==== tb/sbac_host_model.sv ====
// Purpose: Host side of the burst SRAM pins, one bus cycle per step
// Assumes: Steps are driven just after a rising edge and sampled at the next
// Notes:   Data lines show the inverse of the last value in steps with global write and byte enable both high
module sbac_host_model (
    input  wire logic   clock,
    output logic [3:0]  ext_addr,
    output logic [2:0]  ce,
    output logic [3:0]  ctl_n,
    output logic [5:0]  wr_n,
    output logic [35:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Idle levels
    initial begin
        ext_addr = 4'h0;
        ce = 3'b100;
        ctl_n = 4'hF;
        wr_n = 6'h3F;
        data_in = 36'h0_0000_0000;
    end
    // ==========================================
    // One cycle: ctl_n {proc, ctrl, advance, oe}, ce {primary_n, hi, secondary_n},
    // wr_n {global, byte enable, lanes d..a}
    task automatic step(input logic [3:0] c, input logic [2:0] e, input logic [5:0] w,
                        input logic [3:0] a, input logic [35:0] d);
        @(posedge clock);
        ctl_n <= c;
        ce <= e;
        wr_n <= w;
        ext_addr <= a;
        data_in <= (w[5] & w[4]) ? ~data_in : d;
    endtask
endmodule // sbac_host_model

// ==== tb/sbac_top_tb.sv ====
// Purpose: Self-checking bench of the burst SRAM front end
// Assumes: Default address width, registers over Avalon-MM
// Notes:   Expected array contents kept in mem
`include "sbac_params.svh"
module sbac_top_tb
    import sbac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        burst_order_sel = 1'b0;
    logic [3:0]  ext_addr;
    logic [2:0]  ce;
    logic [3:0]  ctl_n;
    logic [5:0]  wr_n;
    logic [35:0] data_in;
    logic [35:0] data_out;
    logic        data_oe_n;
    logic [35:0] mem [16];
    logic [31:0] q;
    sbac_org_t   org = SBAC_X36;
    int          failures = 0;
    int          num_checks = 0;
    always #20 clock = ~clock;
    sbac_host_model host_i (.clock(clock), .ext_addr(ext_addr), .ce(ce), .ctl_n(ctl_n),
        .wr_n(wr_n), .data_in(data_in));
    sbac_top sbac_top_i (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_addr(ext_addr), .chip_sel_n(ce[2]), .chip_sel_hi(ce[1]),
        .chip_sel_secondary_n(ce[0]), .proc_addr_strobe_n(ctl_n[3]),
        .ctrl_addr_strobe_n(ctl_n[2]), .burst_advance_n(ctl_n[1]), .out_enable_n(ctl_n[0]),
        .global_write_n(wr_n[5]), .byte_write_enable_n(wr_n[4]), .lane_a_write_n(wr_n[0]),
        .lane_b_write_n(wr_n[1]), .lane_c_write_n(wr_n[2]), .lane_d_write_n(wr_n[3]),
        .burst_order_sel(burst_order_sel), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n));
    // ==========================================
    // Helpers
    function automatic logic [35:0] lane_mask(input sbac_org_t o, input logic [3:0] en);
        lane_mask = 36'h0_0000_0000;
        for (int n = 0; n < 4; n++) begin
            if (en[n] && (o != SBAC_X18 || n < 2)) begin
                lane_mask[8*n +: 8] = 8'hFF;
                lane_mask[32+n] = (o != SBAC_X32);
            end
        end
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic set_org(input sbac_org_t o);
        av(1'b1, `SBAC_OFF_CTRL, {30'h0, o});
        org = o;
    endtask
    task automatic stat_chk(input logic [1:0] exp);
        av(1'b0, `SBAC_OFF_STAT, 32'h0000_0000);
        chk(36'(q[3:2]), 36'(exp));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        av(1'b0, `SBAC_OFF_CTRL, 32'h0000_0000);
        chk(36'(q), 36'h0_0000_0002);
        av(1'b1, `SBAC_OFF_CTRL, 32'h0000_0003);
        av(1'b1, 4'hC, 32'h0000_0001);
        av(1'b0, 4'hC, 32'h0000_0000);
        chk(36'(q), 36'h0_0000_0000);
        av(1'b0, `SBAC_OFF_CTRL, 32'h0000_0000);
        chk(36'(q), 36'h0_0000_0002);
    endtask
    task automatic sram_wr(input logic [3:0] a, input logic [5:0] w, input logic [35:0] d);
        logic [35:0] m;
        m = lane_mask(org, !w[5] ? 4'hF : (!w[4] ? ~w[3:0] : 4'h0));
        host_i.step(4'b1010, 3'b010, w, a, d);
        mem[a] = (mem[a] & ~m) | (d & m);
    endtask
    task automatic rd_burst(input logic [3:0] a, input logic il);
        logic [1:0] cnt [5];
        logic [1:0] ix;
        cnt = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd3};
        for (int k = 0; k < 8; k++) begin
            host_i.step(k == 0 ? 4'b0010 : {3'b111, 1'b0} & ~{2'b00, k == 1 || k > 2 && k < 5, 1'b0},
                3'b010, k == 0 ? 6'h1F : 6'h3F, a, 36'h5_A5A5_A5A5);
            if (k >= 2 && k < 7) begin
                #1;
                ix = il ? a[1:0] ^ cnt[k-2] : a[1:0] + cnt[k-2];
                chk(data_out, mem[{a[3:2], ix}] & lane_mask(org, 4'hF));
                chk(36'(data_oe_n), 36'h0_0000_0000);
            end
        end
    endtask
    task automatic t_bursts();
        for (int i = 0; i < 4; i++) begin
            sram_wr(4'(4 + i), 6'h1F, 36'h9_C3A5_5A3C + 36'(i) * 36'h1_1111_1111);
        end
        rd_burst(4'h5, 1'b0);
        rd_burst(4'h7, 1'b0);
        host_i.step(4'b1010, 3'b110, 6'h3F, 4'h0, 36'h0);
        @(posedge clock);
        burst_order_sel <= 1'b1;
        rd_burst(4'h6, 1'b1);
        set_org(SBAC_X18);
        sram_wr(4'h5, 6'b101010, 36'hF_FFFF_FFFF);
        rd_burst(4'h4, 1'b1);
        set_org(SBAC_X32);
        sram_wr(4'h6, 6'h1F, 36'h0_0000_0000);
        rd_burst(4'h4, 1'b1);
        set_org(SBAC_X36);
        rd_burst(4'h4, 1'b1);
    endtask
    task automatic t_desel();
        host_i.step(4'b0110, 3'b010, 6'h3F, 4'h6, 36'h0);
        host_i.step(4'b0110, 3'b110, 6'h3F, 4'h9, 36'h0);
        host_i.step(4'b1110, 3'b010, 6'h3F, 4'h9, 36'h0);
        av(1'b0, `SBAC_OFF_ADDR, 32'h0000_0000);
        chk(36'(q), 36'h0_0000_0006);
        stat_chk(2'b01);
        host_i.step(4'b1010, 3'b010, 6'h3F, 4'h9, 36'h0);
        host_i.step(4'b1110, 3'b010, 6'h3F, 4'h9, 36'h0);
        av(1'b0, `SBAC_OFF_ADDR, 32'h0000_0000);
        chk(36'(q), 36'h0_0000_0009);
        for (int i = 0; i < 2; i++) begin
            host_i.step(4'b0110, i ? 3'b011 : 3'b000, 6'h3F, 4'h5, 36'h0);
            host_i.step(4'b1110, 3'b010, 6'h3F, 4'h5, 36'h0);
            stat_chk(2'b10);
            chk(36'(data_oe_n), 36'h0_0000_0001);
        end
        host_i.step(4'b0110, 3'b010, 6'h3F, 4'h5, 36'h0);
        host_i.step(4'b1010, 3'b110, 6'h3F, 4'h5, 36'h0);
        host_i.step(4'b1110, 3'b110, 6'h3F, 4'h5, 36'h0);
        stat_chk(2'b10);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 36'h0_0000_0000;
        end
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_bursts();
        t_desel();
        test_done();
    end
    initial begin
        #200000;
        failures++;
        test_done();
    end
endmodule // sbac_top_tb
